// *** chan_divider.sv ***
// one output channel divider with phase, sync, force and routing
`timescale 1ns/100ps
module chan_divider
  import clkdiv_pkg::*;
(
  // clock and reset
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  // input clock image
  input  wire logic     tick_in,
  input  wire logic     raw_in,
  // control
  input  wire logic     sync_in,
  input  wire logic     src_sel_in,
  input  wire div_cfg_t cfg_in,
  // result
  output logic          out_out,
  output logic          run_out
);

  typedef enum logic [1:0] {ST_HOLD, ST_PHASE, ST_RUN} div_state_t;

  div_state_t state_r;
  logic [3:0] cnt_r;
  logic       level_r;
  logic       prev_r;
  logic       out_r;
  logic       sync_hold;
  logic       direct_eff;
  logic       odd;
  logic       shaped;

  assign sync_hold  = sync_in & ~cfg_in.nosync;
  assign direct_eff = cfg_in.direct & ~src_sel_in;
  assign odd        = cfg_in.low[0] ^ cfg_in.high[0];

  // ----------------------------------------
  // counting
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_HOLD;
      cnt_r   <= 4'h0;
      level_r <= 1'b0;
    end else if (sync_hold || cfg_in.bypass) begin
      // bypass powers the counter down; leaving it restarts like a sync
      state_r <= ST_HOLD;
      level_r <= cfg_in.start_high;
    end else if (tick_in) begin
      case (state_r)
        ST_HOLD: begin
          state_r <= ST_PHASE;
          cnt_r   <= cfg_in.phase;
          level_r <= cfg_in.start_high;
        end
        ST_PHASE: begin
          if (cnt_r == 4'h0) begin
            state_r <= ST_RUN;
            level_r <= cfg_in.start_high;
            cnt_r   <= cfg_in.start_high ? cfg_in.high : cfg_in.low;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_RUN: begin
          if (cnt_r == 4'h0) begin
            level_r <= ~level_r;
            cnt_r   <= level_r ? cfg_in.low : cfg_in.high;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: state_r <= ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------
  // duty correction and output select
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) prev_r <= 1'b0;
    else           prev_r <= level_r;
  end

  // correction when not disabled
  // odd ratios stretch high by half an input cycle
  assign shaped = level_r | (~cfg_in.dcc_off & odd & prev_r & (state_r == ST_RUN));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_r <= 1'b0;
    end else if (direct_eff || cfg_in.bypass) begin
      out_r <= raw_in;
    end else if (cfg_in.force_hi && cfg_in.nosync) begin
      out_r <= cfg_in.start_high;
    end else begin
      out_r <= shaped;
    end
  end

  assign out_out = out_r;
  assign run_out = (state_r == ST_RUN);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic       flip;
  logic [4:0] seg_r;
  logic       full_r;
  logic [5:0] per_r;
  logic       pfull_r;
  div_cfg_t   cfg_q_r;

  assign flip = (state_r == ST_RUN) & tick_in & (cnt_r == 4'h0) & ~sync_hold & ~cfg_in.bypass;

  always_ff @(posedge clk_in) begin
    cfg_q_r <= cfg_in;
    if (!rst_n_in || state_r != ST_RUN || cfg_in != cfg_q_r || sync_hold || cfg_in.bypass) begin
      seg_r   <= 5'h00;
      full_r  <= 1'b0;
      per_r   <= 6'h00;
      pfull_r <= 1'b0;
    end else if (flip) begin
      seg_r  <= 5'h00;
      full_r <= 1'b1;
      per_r  <= level_r ? per_r + 6'h01 : 6'h00;
      if (!level_r) pfull_r <= full_r;
    end else if (tick_in) begin
      seg_r <= seg_r + 5'h01;
      per_r <= per_r + 6'h01;
    end
  end

  low_length_a: assert property (flip && full_r && !level_r |-> seg_r == {1'b0, cfg_in.low})
    else $error("low phase length wrong");
  high_length_a: assert property (flip && full_r && level_r |-> seg_r == {1'b0, cfg_in.high})
    else $error("high phase length wrong");
  period_sum_a: assert property (flip && pfull_r && !level_r |->
      per_r == 6'({2'b00, cfg_in.low} + {2'b00, cfg_in.high} + 6'h01))
    else $error("period differs from low plus high");
  bypass_raw_a: assert property (cfg_in.bypass && !direct_eff |=> out_r == $past(raw_in))
    else $error("bypass did not pass input");
  sync_hold_a: assert property (sync_hold && !cfg_in.bypass ##1 sync_hold |-> state_r == ST_HOLD
      && level_r == $past(cfg_in.start_high))
    else $error("sync did not hold divider");
  nosync_run_a: assert property (cfg_in.nosync && !cfg_in.bypass && state_r == ST_RUN
      && $stable(cfg_in) |=> state_r == ST_RUN)
    else $error("ignored sync disturbed divider");
  phase_load_a: assert property (state_r == ST_HOLD && tick_in && !sync_hold && !cfg_in.bypass
      |=> state_r == ST_PHASE && cnt_r == $past(cfg_in.phase))
    else $error("phase offset not loaded");
  start_level_a: assert property ($past(state_r) == ST_PHASE && state_r == ST_RUN
      |-> level_r == $past(cfg_in.start_high))
    else $error("wrong start level");
  force_level_a: assert property (cfg_in.force_hi && cfg_in.nosync && !cfg_in.bypass && !direct_eff
      |=> out_r == $past(cfg_in.start_high))
    else $error("force did not hold level");
  direct_route_a: assert property (direct_eff |=> out_r == $past(raw_in))
    else $error("direct route not taken");
  divided_out_a: assert property (!direct_eff && !cfg_in.bypass && !(cfg_in.force_hi && cfg_in.nosync)
      |=> out_r == $past(shaped))
    else $error("pair not driven by divider");
  dcc_off_a: assert property (cfg_in.dcc_off |-> shaped == level_r)
    else $error("correction active while disabled");

  run_flip_c: cover property (flip && full_r);
  sync_seen_c: cover property (sync_hold ##1 !sync_hold);
  force_seen_c: cover property (cfg_in.force_hi && cfg_in.nosync && !cfg_in.bypass);

endmodule : chan_divider

// *** channel_clock_divider.sv ***
// two channel clock dividers with an AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module channel_clock_divider
  import clkdiv_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  // chip-level sync pin
  input  wire logic              SYNC_N_IN,
  // axi write address
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  // axi write data
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  // axi write response
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  // axi read address
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  // axi read data
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  // clock outputs
  output logic                   FIRST_PAIR_OUTPUT_A_OUT,
  output logic                   FIRST_PAIR_OUTPUT_B_OUT,
  output logic                   SECOND_PAIR_OUTPUT_A_OUT,
  output logic                   SECOND_PAIR_OUTPUT_B_OUT
);

  // the index decode reads address bits 11:2
  if (ADDR_W < 12) begin : g_addr_check
    $error("ADDR_W must reach the register indices");
  end

  // ----------------------------------------
  // input clock image and sync pin
  // ----------------------------------------
  logic raw_r;
  logic tick;
  logic sync_m_r;
  logic sync_s_r;
  logic sync_act;

  // one input clock cycle spans two system clocks, so the raw
  // clock can be routed as a level without a second domain
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) raw_r <= 1'b0;
    else           raw_r <= ~raw_r;
  end

  assign tick = ~raw_r;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sync_m_r <= 1'b1;
      sync_s_r <= 1'b1;
    end else begin
      sync_m_r <= SYNC_N_IN;
      sync_s_r <= sync_m_r;
    end
  end

  assign sync_act = ~sync_s_r;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] d0_cnt_r;
  logic [7:0] d0_ctrl_r;
  logic [7:0] d0_route_r;
  logic [7:0] d1_cnt_r;
  logic [7:0] d1_ctrl_r;
  logic [7:0] d1_route_r;
  logic [7:0] src_sel_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic       wr_fire;
  logic       rd_fire;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] rd_byte;
  logic [7:0] status;
  logic       first_pair_output_a;
  logic       first_pair_output_b;
  logic       run0;
  logic       run1;

  assign wr_idx = S_AXI_AWADDR_IN[11:2];
  assign rd_idx = S_AXI_ARADDR_IN[11:2];

  // both write channels are taken together so no half write is held
  assign wr_fire           = S_AXI_AWVALID_IN & S_AXI_WVALID_IN & ~bvalid_r;
  assign S_AXI_AWREADY_OUT = wr_fire;
  assign S_AXI_WREADY_OUT  = wr_fire;
  assign rd_fire           = S_AXI_ARVALID_IN & ~rvalid_r;
  assign S_AXI_ARREADY_OUT = ~rvalid_r;

  always_comb begin
    case (wr_idx)
      IDX_D0_CNT, IDX_D0_CTRL, IDX_D0_ROUTE,
      IDX_D1_CNT, IDX_D1_CTRL, IDX_D1_ROUTE,
      IDX_SRC_SEL, IDX_STATUS: wr_hit = 1'b1;
      default:                 wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      d0_cnt_r   <= RST_D0_CNT;
      d0_ctrl_r  <= RST_D0_CTRL;
      d0_route_r <= RST_D0_ROUTE;
      d1_cnt_r   <= RST_D1_CNT;
      d1_ctrl_r  <= RST_D1_CTRL;
      d1_route_r <= RST_D1_ROUTE;
      src_sel_r  <= RST_SRC_SEL;
    end else if (wr_fire && S_AXI_WSTRB_IN[0]) begin
      case (wr_idx)
        IDX_D0_CNT:   d0_cnt_r   <= S_AXI_WDATA_IN[7:0];
        IDX_D0_CTRL:  d0_ctrl_r  <= S_AXI_WDATA_IN[7:0];
        IDX_D0_ROUTE: d0_route_r <= S_AXI_WDATA_IN[7:0];
        IDX_D1_CNT:   d1_cnt_r   <= S_AXI_WDATA_IN[7:0];
        IDX_D1_CTRL:  d1_ctrl_r  <= S_AXI_WDATA_IN[7:0];
        IDX_D1_ROUTE: d1_route_r <= S_AXI_WDATA_IN[7:0];
        IDX_SRC_SEL:  src_sel_r  <= S_AXI_WDATA_IN[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // write response
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_r <= 1'b0;
    end
  end

  assign S_AXI_BVALID_OUT = bvalid_r;
  assign S_AXI_BRESP_OUT  = bresp_r;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign status = {3'h0, sync_act, run1, run0, first_pair_output_b, first_pair_output_a};

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      IDX_D0_CNT:   rd_byte = d0_cnt_r;
      IDX_D0_CTRL:  rd_byte = d0_ctrl_r;
      IDX_D0_ROUTE: rd_byte = d0_route_r;
      IDX_D1_CNT:   rd_byte = d1_cnt_r;
      IDX_D1_CTRL:  rd_byte = d1_ctrl_r;
      IDX_D1_ROUTE: rd_byte = d1_route_r;
      IDX_SRC_SEL:  rd_byte = src_sel_r;
      IDX_STATUS:   rd_byte = status;
      default:      rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= {24'h00_0000, rd_byte};
    end else if (S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_RVALID_OUT = rvalid_r;
  assign S_AXI_RRESP_OUT  = rresp_r;
  assign S_AXI_RDATA_OUT  = rdata_r;

  // ----------------------------------------
  // channels
  // ----------------------------------------
  div_cfg_t cfg0;
  div_cfg_t cfg1;

  assign cfg0 = unpack_cfg(d0_cnt_r, d0_ctrl_r, d0_route_r);
  assign cfg1 = unpack_cfg(d1_cnt_r, d1_ctrl_r, d1_route_r);

  chan_divider u_div0 (
    .clk_in     (CLK_IN),
    .rst_n_in   (RST_N_IN),
    .tick_in    (tick),
    .raw_in     (raw_r),
    .sync_in    (sync_act),
    .src_sel_in (src_sel_r[SRC_BIT]),
    .cfg_in     (cfg0),
    .out_out    (first_pair_output_a),
    .run_out    (run0)
  );

  chan_divider u_div1 (
    .clk_in     (CLK_IN),
    .rst_n_in   (RST_N_IN),
    .tick_in    (tick),
    .raw_in     (raw_r),
    .sync_in    (sync_act),
    .src_sel_in (src_sel_r[SRC_BIT]),
    .cfg_in     (cfg1),
    .out_out    (first_pair_output_b),
    .run_out    (run1)
  );

  // pair members are complements, both from the channel flop
  assign FIRST_PAIR_OUTPUT_A_OUT  = first_pair_output_a;
  assign FIRST_PAIR_OUTPUT_B_OUT  = ~first_pair_output_a;
  assign SECOND_PAIR_OUTPUT_A_OUT = first_pair_output_b;
  assign SECOND_PAIR_OUTPUT_B_OUT = ~first_pair_output_b;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // reset count and bypass values
  d1_reset_a: assert property (@(posedge CLK_IN) !RST_N_IN |=> d1_cnt_r[7:4] == 4'hB)
    else $error("second low count reset wrong");
  d1_bypass_a: assert property (@(posedge CLK_IN) !RST_N_IN |=> !d1_ctrl_r[BYP_BIT])
    else $error("second bypass reset wrong");
  bus_write_c: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN) wr_fire && wr_hit);

endmodule : channel_clock_divider

// *** channel_clock_divider_test.sv ***
// self-checking bench for the channel clock divider
`timescale 1ns/100ps
module channel_clock_divider_test;
  import clkdiv_pkg::*;

  logic        clk, rst_n, sync_n;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        a0, b0, a1, b1;
  int          hi0, lo0, run0, ed0, bad0, hi1, lo1, run1, ed1, bad1;
  int          fails, checked;
  int          edges_seen;

  // free cycle count: its parity tracks the divider input clock phase
  initial edges_seen = 0;
  always @(posedge clk) edges_seen <= edges_seen + 1;

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end

  channel_clock_divider DUT (
    .CLK_IN(clk), .RST_N_IN(rst_n), .SYNC_N_IN(sync_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .FIRST_PAIR_OUTPUT_A_OUT(a0), .FIRST_PAIR_OUTPUT_B_OUT(b0),
    .SECOND_PAIR_OUTPUT_A_OUT(a1), .SECOND_PAIR_OUTPUT_B_OUT(b1));

  clk_pair_monitor mon0 (.clk_in(clk), .a_in(a0), .b_in(b0), .hi_len_out(hi0), .lo_len_out(lo0),
    .run_out(run0), .edges_out(ed0), .pair_bad_out(bad0));
  clk_pair_monitor mon1 (.clk_in(clk), .a_in(a1), .b_in(b1), .hi_len_out(hi1), .lo_len_out(lo1),
    .run_out(run1), .edges_out(ed1), .pair_bad_out(bad1));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // closing and bus tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ready is sampled mid-cycle, inputs only move at rising edges
  task automatic wait_hi(ref logic s);
    int  n;
    logic ok;
    n = 0;
    do begin
      @(negedge clk);
      ok = s;
      @(posedge clk);
      n++;
    end while (!ok && n < 100);
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t bus wait ran out", $time);
      final_report();
    end
  endtask : wait_hi

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {idx, 2'h0}; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    wait_hi(awready);
    awvalid <= 1'b0; wvalid <= 1'b0;
    @(negedge clk);
    r = bresp;
    if (!bvalid) wait_hi(bvalid); else @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    `CHK(r, er)
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'h0}; arvalid <= 1'b1; rready <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    rready <= 1'b0;
    `CHK(rdata, {24'h0, ed})
    `CHK(rresp, er)
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    rd(IDX_D1_CNT, 8'hB0, RESP_OKAY);
    rd(IDX_D1_CTRL, 8'h00, RESP_OKAY);
    rd(IDX_D0_CTRL, 8'h80, RESP_OKAY);
    rd(IDX_D0_ROUTE, 8'h00, RESP_OKAY);
    rd(IDX_D1_ROUTE, 8'h00, RESP_OKAY);
    rd(IDX_SRC_SEL, 8'h00, RESP_OKAY);
    wr(10'h100, 8'h5A, RESP_SLVERR);
    rd(10'h100, 8'h00, RESP_SLVERR);
    // a write without the low byte lane is answered but not applied
    wstrb <= 4'h0;
    wr(IDX_SRC_SEL, 8'h01, RESP_OKAY);
    wstrb <= 4'hF;
    rd(IDX_SRC_SEL, 8'h00, RESP_OKAY);
    cyc(10);
    // ch0 is bypassed out of reset and follows the input clock
    `CHK(hi0, 1)
    `CHK(lo0, 1)
  endtask : t_reset_values

  task automatic t_divide();
    wr(IDX_D1_ROUTE, 8'h01, RESP_OKAY);
    wr(IDX_D1_CNT, 8'h72, RESP_OKAY);
    rd(IDX_D1_CNT, 8'h72, RESP_OKAY);
    cyc(100);
    `CHK(lo1, 16)
    `CHK(hi1, 6)
    // odd ratio with correction on: high widened by half an input cycle
    wr(IDX_D1_ROUTE, 8'h00, RESP_OKAY);
    cyc(100);
    `CHK(hi1, 7)
    `CHK(hi1 + lo1, 22)
  endtask : t_divide

  task automatic t_bypass_force();
    wr(IDX_D1_CTRL, 8'h80, RESP_OKAY);
    cyc(20);
    `CHK(hi1, 1)
    `CHK(lo1, 1)
    wr(IDX_D1_CTRL, 8'h70, RESP_OKAY);
    cyc(40);
    `CHK(a1, 1'b1)
    `CHK(run1 >= 30, 1'b1)
    wr(IDX_D1_CTRL, 8'hF0, RESP_OKAY);
    cyc(20);
    `CHK(hi1, 1)
    `CHK(lo1, 1)
  endtask : t_bypass_force

  task automatic t_sync();
    int e;
    wr(IDX_D1_ROUTE, 8'h01, RESP_OKAY);
    wr(IDX_D1_CNT, 8'h11, RESP_OKAY);
    wr(IDX_D1_CTRL, 8'h00, RESP_OKAY);
    sync_n <= 1'b0;
    cyc(50);
    `CHK(a1, 1'b0)
    `CHK(run1 >= 40, 1'b1)
    wr(IDX_D1_CTRL, 8'h10, RESP_OKAY);
    cyc(50);
    `CHK(a1, 1'b1)
    wr(IDX_D1_CTRL, 8'h40, RESP_OKAY);
    cyc(10);
    e = ed1;
    cyc(40);
    `CHK((ed1 - e) >= 8, 1'b1)
    @(posedge clk);
    sync_n <= 1'b1;
  endtask : t_sync

  task automatic phase_delay(input logic [7:0] ctrl, output int d);
    wr(IDX_D1_CTRL, ctrl, RESP_OKAY);
    @(posedge clk);
    sync_n <= 1'b0;
    cyc(20);
    @(posedge clk);
    // release on one input clock phase so both runs start alike
    if (edges_seen % 2 != 0) @(posedge clk);
    sync_n <= 1'b1;
    d = 0;
    do begin
      @(negedge clk);
      d++;
    end while (a1 !== 1'b1 && d < 200);
    if (d >= 200) begin
      fails++;
      $display("[FAIL] %0t output never rose after sync", $time);
      final_report();
    end
  endtask : phase_delay

  task automatic t_phase();
    int d0, d3;
    phase_delay(8'h00, d0);
    phase_delay(8'h03, d3);
    // three coarse steps of one input cycle each
    `CHK(d3 - d0, 6)
  endtask : t_phase

  task automatic t_route();
    wr(IDX_D0_CNT, 8'h33, RESP_OKAY);
    wr(IDX_D0_CTRL, 8'h00, RESP_OKAY);
    cyc(60);
    `CHK(hi0, 8)
    `CHK(lo0, 8)
    wr(IDX_D0_ROUTE, 8'h02, RESP_OKAY);
    cyc(20);
    `CHK(hi0, 1)
    `CHK(lo0, 1)
    wr(IDX_SRC_SEL, 8'h01, RESP_OKAY);
    cyc(60);
    `CHK(hi0, 8)
    `CHK(lo0, 8)
  endtask : t_route

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fails = 0; checked = 0;
    rst_n = 1'b0; sync_n = 1'b1;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hF;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_divide();
    t_bypass_force();
    t_sync();
    t_phase();
    t_route();
    `CHK(bad0 + bad1 <= 2, 1'b1)
    final_report();
  end
endmodule : channel_clock_divider_test

// *** clk_pair_monitor.sv ***
// downstream consumer model that measures one differential clock pair
`timescale 1ns/100ps
module clk_pair_monitor (
  // clock
  input  wire logic clk_in,
  // observed pair
  input  wire logic a_in,
  input  wire logic b_in,
  // measurements in system clock cycles, except the edge count
  output int        hi_len_out,
  output int        lo_len_out,
  output int        run_out,
  output int        edges_out,
  output int        pair_bad_out
);
  logic a_q;

  initial begin
    a_q          = 1'b0;
    hi_len_out   = 0;
    lo_len_out   = 0;
    run_out      = 0;
    edges_out    = 0;
    pair_bad_out = 0;
  end

  // ----------------------------------------
  // run length of each level
  // ----------------------------------------
  // a receiver only sees levels, so lengths are counted in sampling cycles
  always @(posedge clk_in) begin
    if (a_in !== a_q) begin
      if (a_q) hi_len_out <= run_out;
      else lo_len_out <= run_out;
      run_out   <= 1;
      edges_out <= edges_out + 1;
    end else begin
      run_out <= run_out + 1;
    end
    a_q <= a_in;
    if (b_in !== ~a_in) pair_bad_out <= pair_bad_out + 1;
  end
endmodule : clk_pair_monitor

// *** clkdiv_pkg.sv ***
// shared constants and types for the channel clock divider
package clkdiv_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_D0_CNT   = 10'h190;
  localparam logic [9:0] IDX_D0_CTRL  = 10'h191;
  localparam logic [9:0] IDX_D0_ROUTE = 10'h192;
  localparam logic [9:0] IDX_D1_CNT   = 10'h193;
  localparam logic [9:0] IDX_D1_CTRL  = 10'h194;
  localparam logic [9:0] IDX_D1_ROUTE = 10'h195;
  localparam logic [9:0] IDX_SRC_SEL  = 10'h1E1;
  localparam logic [9:0] IDX_STATUS   = 10'h1F0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_D0_CNT   = 8'h00;
  localparam logic [7:0] RST_D0_CTRL  = 8'h80;
  localparam logic [7:0] RST_D0_ROUTE = 8'h00;
  localparam logic [7:0] RST_D1_CNT   = 8'hB0;
  localparam logic [7:0] RST_D1_CTRL  = 8'h00;
  localparam logic [7:0] RST_D1_ROUTE = 8'h00;
  localparam logic [7:0] RST_SRC_SEL  = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BYP_BIT    = 7;
  localparam int NOSYNC_BIT = 6;
  localparam int FORCE_BIT  = 5;
  localparam int START_BIT  = 4;
  localparam int DIRECT_BIT = 1;
  localparam int DCC_BIT    = 0;
  localparam int SRC_BIT    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
    logic       bypass;
    logic       nosync;
    logic       force_hi;
    logic       start_high;
    logic [3:0] phase;
    logic       direct;
    logic       dcc_off;
  } div_cfg_t;

  function automatic div_cfg_t unpack_cfg(input logic [7:0] cnt,
                                          input logic [7:0] ctrl,
                                          input logic [7:0] route);
    div_cfg_t c;
    c.low        = cnt[7:4];
    c.high       = cnt[3:0];
    c.bypass     = ctrl[BYP_BIT];
    c.nosync     = ctrl[NOSYNC_BIT];
    c.force_hi   = ctrl[FORCE_BIT];
    c.start_high = ctrl[START_BIT];
    c.phase      = ctrl[3:0];
    c.direct     = route[DIRECT_BIT];
    c.dcc_off    = route[DCC_BIT];
    return c;
  endfunction : unpack_cfg

endpackage : clkdiv_pkg
